/* include/gpiom_regs.vh */
// Register map and field layout of the eight-bit port M block
`ifndef GPIOM_REGS_VH
`define GPIOM_REGS_VH
`define GPIOM_ADDR_W         8
`define GPIOM_OFF_DATA       8'h00
`define GPIOM_OFF_OUT_EN     8'h04
`define GPIOM_OFF_ALT_ONE    8'h08
`define GPIOM_OFF_ALT_TWO    8'h0c
`define GPIOM_OFF_ALT_THREE  8'h10
`define GPIOM_OFF_OPEN_DRAIN 8'h28
`define GPIOM_OFF_PULLUP     8'h2c
`define GPIOM_OFF_IN_EN      8'h38
`define GPIOM_OFF_PIN_LEVEL  8'h3c
`define GPIOM_RESET_BYTE     8'h00
`define GPIOM_ALT_TWO_MASK   8'h0f
`define GPIOM_ALT_THREE_MASK 8'h11
`define GPIOM_FULL_MASK      8'hff
`define GPIOM_RESP_OKAY      2'b00
`define GPIOM_RESP_SLVERR    2'b10
`define GPIOM_SYNC_RESET     8'h00
`endif

/* rtl/gpiom_sync.v */
// Two flip-flop synchroniser for the pad input levels
module gpiom_sync #(
    parameter WIDTH = 8
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

/* rtl/gpiom_port.v */
// Port M pin logic: AXI4-Lite registers, function routing and pad control
//
// Our own choice: the AXI4-Lite interface to the registers.
`include "gpiom_regs.vh"
module gpiom_port #(
    parameter PINS = 8
) (
    input  wire            aclk,
    input  wire            aresetn,
    input  wire [7:0]      s_axi_awaddr,
    input  wire            s_axi_awvalid,
    output reg             s_axi_awready,
    input  wire [31:0]     s_axi_wdata,
    input  wire [3:0]      s_axi_wstrb,
    input  wire            s_axi_wvalid,
    output reg             s_axi_wready,
    output reg  [1:0]      s_axi_bresp,
    output reg             s_axi_bvalid,
    input  wire            s_axi_bready,
    input  wire [7:0]      s_axi_araddr,
    input  wire            s_axi_arvalid,
    output reg             s_axi_arready,
    output reg  [31:0]     s_axi_rdata,
    output reg  [1:0]      s_axi_rresp,
    output reg             s_axi_rvalid,
    input  wire            s_axi_rready,
    input  wire [PINS-1:0] pad_in,
    output reg  [PINS-1:0] pad_out,
    output reg  [PINS-1:0] pad_oe_n,
    output reg  [PINS-1:0] pad_pullup_en,
    output reg  [PINS-1:0] pad_input_en,
    input  wire            stop_mode,
    input  wire            stop_mode_pin_drive_enable,
    input  wire            serial_transmit_two,
    input  wire            serial_clock_two_out,
    input  wire            serial_transmit_three,
    input  wire            serial_clock_three_out,
    input  wire            timer_output_three,
    input  wire            alarm_output,
    output reg             serial_receive_two,
    output reg             serial_receive_three,
    output reg             serial_clock_two_in,
    output reg             serial_clock_three_in,
    output reg             external_interrupt_two,
    output reg             external_interrupt_three,
    output reg             timer_one_capture_input_zero,
    output reg             timer_one_capture_input_one,
    output reg             clear_to_send_two,
    output reg             clear_to_send_three
);
    ////////////////////////////////////////////////////////////////////////////
    reg  [7:0] port_m_pin_data_reg;
    reg  [7:0] port_m_output_enable_reg;
    reg  [7:0] port_m_alt_select_one_reg;
    reg  [7:0] port_m_alt_select_two_reg;
    reg  [7:0] port_m_alt_select_three_reg;
    reg  [7:0] port_m_open_drain_select_reg;
    reg  [7:0] port_m_pullup_enable_reg;
    reg  [7:0] port_m_input_enable_reg;
    reg  [7:0] aw_addr_reg;
    reg        aw_held_reg;
    reg [31:0] w_data_reg;
    reg  [3:0] w_strb_reg;
    reg        w_held_reg;
    wire [7:0] pin_level;

    gpiom_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pad_in),
        .sync_out (pin_level)
    );

    // Offset decode shared by both channels
    function known_offset;
        input [7:0] a;
        begin
            case (a)
                `GPIOM_OFF_DATA, `GPIOM_OFF_OUT_EN, `GPIOM_OFF_ALT_ONE,
                `GPIOM_OFF_ALT_TWO, `GPIOM_OFF_ALT_THREE, `GPIOM_OFF_OPEN_DRAIN,
                `GPIOM_OFF_PULLUP, `GPIOM_OFF_IN_EN, `GPIOM_OFF_PIN_LEVEL:
                    known_offset = 1'b1;
                default: known_offset = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write path: address and data taken in either order, then one response
    wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [7:0] wbyte = w_data_reg[7:0];
    wire       wlane = w_strb_reg[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= `GPIOM_RESET_BYTE;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `GPIOM_RESP_OKAY;
            port_m_pin_data_reg          <= `GPIOM_RESET_BYTE;
            port_m_output_enable_reg     <= `GPIOM_RESET_BYTE;
            port_m_alt_select_one_reg    <= `GPIOM_RESET_BYTE;
            port_m_alt_select_two_reg    <= `GPIOM_RESET_BYTE;
            port_m_alt_select_three_reg  <= `GPIOM_RESET_BYTE;
            port_m_open_drain_select_reg <= `GPIOM_RESET_BYTE;
            port_m_pullup_enable_reg     <= `GPIOM_RESET_BYTE;
            port_m_input_enable_reg      <= `GPIOM_RESET_BYTE;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_offset(aw_addr_reg) ? `GPIOM_RESP_OKAY
                                                          : `GPIOM_RESP_SLVERR;
                // Only byte lane 0 holds bits; upper lanes are ignored
                if (wlane) begin
                    case (aw_addr_reg)
                        `GPIOM_OFF_DATA:       port_m_pin_data_reg <= wbyte;
                        `GPIOM_OFF_OUT_EN:     port_m_output_enable_reg <= wbyte;
                        `GPIOM_OFF_ALT_ONE:    port_m_alt_select_one_reg <= wbyte;
                        `GPIOM_OFF_ALT_TWO:
                            port_m_alt_select_two_reg <= wbyte & `GPIOM_ALT_TWO_MASK;
                        `GPIOM_OFF_ALT_THREE:
                            port_m_alt_select_three_reg <= wbyte & `GPIOM_ALT_THREE_MASK;
                        `GPIOM_OFF_OPEN_DRAIN: port_m_open_drain_select_reg <= wbyte;
                        `GPIOM_OFF_PULLUP:     port_m_pullup_enable_reg <= wbyte;
                        `GPIOM_OFF_IN_EN:      port_m_input_enable_reg <= wbyte;
                        default: ;
                    endcase
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: one cycle from address taken to data valid
    reg [7:0] rbyte;
    always @* begin
        case (s_axi_araddr)
            `GPIOM_OFF_DATA:       rbyte = port_m_pin_data_reg;
            `GPIOM_OFF_OUT_EN:     rbyte = port_m_output_enable_reg;
            `GPIOM_OFF_ALT_ONE:    rbyte = port_m_alt_select_one_reg;
            `GPIOM_OFF_ALT_TWO:    rbyte = port_m_alt_select_two_reg;
            `GPIOM_OFF_ALT_THREE:  rbyte = port_m_alt_select_three_reg;
            `GPIOM_OFF_OPEN_DRAIN: rbyte = port_m_open_drain_select_reg;
            `GPIOM_OFF_PULLUP:     rbyte = port_m_pullup_enable_reg;
            `GPIOM_OFF_IN_EN:      rbyte = port_m_input_enable_reg;
            // Synchronised pad levels, gated by input enable
            `GPIOM_OFF_PIN_LEVEL:  rbyte = pin_level & port_m_input_enable_reg;
            default:               rbyte = `GPIOM_RESET_BYTE;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `GPIOM_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rbyte};
                s_axi_rresp  <= known_offset(s_axi_araddr) ? `GPIOM_RESP_OKAY
                                                           : `GPIOM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin routing; overlapping selects are the software's fault, an output
    // function wins over an input so the pin still has one defined source
    wire [7:0] sel_one   = port_m_alt_select_one_reg;
    wire [7:0] sel_two   = port_m_alt_select_two_reg;
    wire [7:0] sel_three = port_m_alt_select_three_reg;
    wire [7:0] in_en     = port_m_input_enable_reg;
    wire [7:0] gated_in  = pin_level & in_en;
    // Pins whose selected function is a peripheral output
    wire [7:0] func_out_sel = {1'b0, 1'b0, sel_one[5], sel_one[4], 1'b0, 1'b0,
                               sel_one[1], sel_one[0]} |
                              {4'h0, sel_two[3], sel_two[2], 2'b00};
    wire [7:0] func_out_val = {2'b00, serial_transmit_three, serial_clock_three_out,
                               2'b00, serial_transmit_two, serial_clock_two_out} |
                              {4'h0, timer_output_three, alarm_output, 2'b00};
    // Pins routed to a peripheral input: output driver stays off
    wire [7:0] func_in_sel  = {sel_one[7], sel_one[6], 2'b00, sel_one[3], sel_one[2],
                               2'b00} | {6'h00, sel_two[1:0]} | sel_three;
    // Stop mode with drive off releases pins; wake inputs keep their path
    wire drive_ok = !stop_mode || stop_mode_pin_drive_enable;

    reg [7:0] out_val;
    reg [7:0] drive;
    integer i;
    always @* begin
        out_val = `GPIOM_RESET_BYTE;
        drive   = `GPIOM_RESET_BYTE;
        for (i = 0; i < PINS; i = i + 1) begin
            if (func_out_sel[i]) begin
                out_val[i] = func_out_val[i];
                drive[i]   = 1'b1;
            end else if (!func_in_sel[i]) begin
                out_val[i] = port_m_pin_data_reg[i];
                drive[i]   = port_m_output_enable_reg[i];
            end
            // Open-drain only pulls low; a high level is released
            if (port_m_open_drain_select_reg[i] && out_val[i]) begin
                drive[i] = 1'b0;
            end
            if (!drive_ok) begin
                drive[i] = 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            pad_out       <= `GPIOM_RESET_BYTE;
            pad_oe_n      <= `GPIOM_FULL_MASK;
            pad_pullup_en <= `GPIOM_RESET_BYTE;
            pad_input_en  <= `GPIOM_RESET_BYTE;
            serial_receive_two           <= 1'b0;
            serial_receive_three         <= 1'b0;
            serial_clock_two_in          <= 1'b0;
            serial_clock_three_in        <= 1'b0;
            external_interrupt_two       <= 1'b0;
            external_interrupt_three     <= 1'b0;
            timer_one_capture_input_zero <= 1'b0;
            timer_one_capture_input_one  <= 1'b0;
            clear_to_send_two            <= 1'b0;
            clear_to_send_three          <= 1'b0;
        end else begin
            pad_out       <= out_val;
            pad_oe_n      <= ~drive;
            pad_pullup_en <= port_m_pullup_enable_reg;
            pad_input_en  <= in_en;
            serial_receive_two    <= gated_in[2] & sel_one[2];
            serial_receive_three  <= gated_in[6] & sel_one[6];
            serial_clock_two_in   <= gated_in[0] & sel_one[0];
            serial_clock_three_in <= gated_in[4] & sel_one[4];
            // In stop mode only selected inputs wake; otherwise enable alone
            external_interrupt_two   <= gated_in[3] & (sel_one[3] | !stop_mode);
            external_interrupt_three <= gated_in[7] & (sel_one[7] | !stop_mode);
            timer_one_capture_input_zero <= gated_in[0] & sel_two[0];
            timer_one_capture_input_one  <= gated_in[1] & sel_two[1];
            clear_to_send_two   <= gated_in[0] & sel_three[0];
            clear_to_send_three <= gated_in[4] & sel_three[4];
        end
    end
endmodule

/* sim/gpiom_port_sva.sv */
// Port-level assertions for the port M block
module gpiom_sva (
    input logic        aclk,
    input logic        aresetn,
    input logic [7:0]  s_axi_awaddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic [7:0]  pad_in,
    input logic [7:0]  pad_oe_n,
    input logic [7:0]  pad_pullup_en,
    input logic [7:0]  pad_input_en,
    input logic        stop_mode,
    input logic        stop_mode_pin_drive_enable,
    input logic        external_interrupt_two,
    input logic        external_interrupt_three
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Offsets with bits 7-6 set lie beyond every register
    sequence s_aw_far;
        s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:6] != 2'b00;
    endsequence
    sequence s_ar_far;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:6] != 2'b00;
    endsequence
    property p_reset_idle;
        $rose(aresetn) |-> pad_oe_n == 8'hff && pad_pullup_en == 8'h00 && pad_input_en == 8'h00;
    endproperty
    property p_write_far;
        s_aw_far |-> ##[1:8] (s_axi_bvalid && s_axi_bresp == 2'b10);
    endproperty
    property p_read_far;
        s_ar_far |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
    endproperty
    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    property p_awready_pulse;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    property p_int_off;
        (!pad_input_en[3]) [*3] |-> !external_interrupt_two;
    endproperty
    // Three cycles of synchroniser and output register before the level shows
    property p_int_on;
        (!stop_mode && pad_input_en[7] && pad_in[7]) [*4] |-> external_interrupt_three;
    endproperty
    property p_stop_release;
        (stop_mode && !stop_mode_pin_drive_enable) [*2] |-> pad_oe_n == 8'hff;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pads not idle");
    a_write_far: assert property (p_write_far) else $error("no write error");
    a_read_far: assert property (p_read_far) else $error("no read error");
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
    a_awready_pulse: assert property (p_awready_pulse) else $error("awready held");
    a_int_off: assert property (p_int_off) else $error("interrupt leaks");
    a_int_on: assert property (p_int_on) else $error("interrupt missing");
    a_stop_release: assert property (p_stop_release) else $error("pins driven");
endmodule

bind gpiom_port gpiom_sva u_sva (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .pad_in, .pad_oe_n, .pad_pullup_en, .pad_input_en,
    .stop_mode, .stop_mode_pin_drive_enable, .external_interrupt_two,
    .external_interrupt_three
);

/* sim/testbench.sv */
// Self-checking testbench for the port M block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pad_in = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        stop_mode = 1'b0, stop_mode_pin_drive_enable = 1'b1;
    logic [5:0]  fn_src = 6'h00;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0]  pad_out, pad_oe_n, pad_pullup_en, pad_input_en;
    logic        serial_receive_two, serial_receive_three, serial_clock_two_in;
    logic        serial_clock_three_in, external_interrupt_two, external_interrupt_three;
    logic        timer_one_capture_input_zero, timer_one_capture_input_one;
    logic        clear_to_send_two, clear_to_send_three;
    int          num_errors = 0, checks = 0;
    logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h28, 8'h2c, 8'h38};
    wire  [5:0]  fn_in = {timer_one_capture_input_one, timer_one_capture_input_zero,
        external_interrupt_three, serial_receive_three, external_interrupt_two,
        serial_receive_two};
    wire  [3:0]  cts_int = {clear_to_send_three, clear_to_send_two,
        external_interrupt_three, external_interrupt_two};
    always #10 aclk = ~aclk;
    gpiom_port uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe_n,
        .pad_pullup_en, .pad_input_en, .stop_mode, .stop_mode_pin_drive_enable,
        .serial_clock_two_out(fn_src[0]), .serial_transmit_two(fn_src[1]),
        .alarm_output(fn_src[2]), .timer_output_three(fn_src[3]),
        .serial_clock_three_out(fn_src[4]), .serial_transmit_three(fn_src[5]),
        .serial_receive_two, .serial_receive_three, .serial_clock_two_in,
        .serial_clock_three_in, .external_interrupt_two, .external_interrupt_three,
        .timer_one_capture_input_zero, .timer_one_capture_input_one,
        .clear_to_send_two, .clear_to_send_three
    );
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] fmask(input int i);
        return (i == 3) ? 32'h0f : ((i == 4) ? 32'h11 : 32'hff);
    endfunction
    function automatic logic [5:0] in_exp(input logic [7:0] p);
        return {p[1], p[0], p[7], p[6], p[3], p[2]};
    endfunction
    task automatic final_report;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo;
        num_errors++;
        final_report();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Address and data offered together; each is released on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        // bready stays high between writes so it is never lowered and raised in one step
        r = s_axi_bresp;
        if (n == 50) tmo();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 50) tmo();
    endtask
    task automatic wo(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d, x;
        logic [1:0]  r;
        logic [7:0]  e, p;
        void'($urandom(32'h609d));
        do_reset();
        for (int i = 0; i < 8; i++) begin
            x = $urandom();
            wo(offs[i], x);
            rd(offs[i], d, r);
            chk("readback", x & fmask(i), d);
        end
        // Second reset mid-run must clear what the random pass left behind
        do_reset();
        chk("oe_n", 32'hff, {24'h0, pad_oe_n});
        chk("pads", 32'h0, {16'h0, pad_pullup_en, pad_input_en});
        for (int i = 0; i < 8; i++) begin
            rd(offs[i], d, r);
            chk("reset value", 32'h0, d);
        end
        wr(8'h80, 32'hffffffff, r);
        chk("far bresp", 32'h2, {30'h0, r});
        rd(8'h14, d, r);
        chk("hole rdata", 32'h0, d);
        chk("hole rresp", 32'h2, {30'h0, r});
        rd(8'h44, d, r);
        chk("far rresp", 32'h2, {30'h0, r});
        x = $urandom();
        e = 8'($urandom());
        wo(8'h00, x);
        wo(8'h04, {24'h0, e});
        repeat (2) @(posedge aclk);
        chk("oe_n gpio", {24'h0, ~e}, {24'h0, pad_oe_n});
        chk("out gpio", {24'h0, x[7:0] & e}, {24'h0, pad_out & e});
        wo(8'h28, 32'hff);
        repeat (2) @(posedge aclk);
        chk("oe_n drain", {24'h0, ~(e & ~x[7:0])}, {24'h0, pad_oe_n});
        p = 8'($urandom());
        wo(8'h2c, {24'h0, p});
        wo(8'h38, {24'h0, ~p});
        repeat (2) @(posedge aclk);
        chk("pullup", {24'h0, p}, {24'h0, pad_pullup_en});
        chk("in_en", {24'h0, ~p}, {24'h0, pad_input_en});
        wo(8'h28, 32'h0);
        wo(8'h04, 32'hff);
        wo(8'h08, 32'h33);
        wo(8'h0c, 32'h0c);
        repeat (2) begin
            fn_src <= 6'($urandom());
            repeat (3) @(posedge aclk);
            chk("fn out", {26'h0, fn_src}, {26'h0, pad_out[5:0]});
        end
        wo(8'h04, 32'h0);
        wo(8'h08, 32'hcc);
        wo(8'h0c, 32'h03);
        wo(8'h38, 32'hff);
        p = 8'($urandom());
        pad_in <= p;
        repeat (4) @(posedge aclk);
        chk("fn in", {26'h0, in_exp(p)}, {26'h0, fn_in});
        wo(8'h08, 32'h0);
        wo(8'h0c, 32'h0);
        wo(8'h10, 32'h11);
        p = 8'($urandom()) | 8'h88;
        pad_in <= p;
        repeat (4) @(posedge aclk);
        chk("cts int", {28'h0, p[4], p[0], p[7], p[3]}, {28'h0, cts_int});
        // Clock inputs of both serial channels; select three cleared first
        wo(8'h10, 32'h0);
        wo(8'h08, 32'h11);
        repeat (4) @(posedge aclk);
        chk("clk in", {30'h0, p[4], p[0]}, {30'h0, serial_clock_three_in, serial_clock_two_in});
        wo(8'h08, 32'h0);
        wo(8'h04, 32'hff);
        stop_mode <= 1'b1;
        stop_mode_pin_drive_enable <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("stop oe_n", 32'hff, {24'h0, pad_oe_n});
        chk("stop int off", 32'h0, {30'h0, cts_int[1:0]});
        wo(8'h08, 32'h88);
        repeat (3) @(posedge aclk);
        chk("stop int on", 32'h3, {30'h0, cts_int[1:0]});
        stop_mode <= 1'b0;
        stop_mode_pin_drive_enable <= 1'b1;
        wo(8'h38, 32'h0);
        repeat (3) @(posedge aclk);
        chk("int masked", 32'h0, {30'h0, cts_int[1:0]});
        final_report();
    end
endmodule
